// *** hw/ufb_pkg.sv ***
// Constants, types and state record of the UART channel
`default_nettype none
package ufb_pkg;
  //**************************************************
  // Register indexes, byte address is four times these
  //**************************************************
  localparam int         ADDR_W      = 12;
  localparam logic [2:0] IDX_DATA    = 3'h0;
  localparam logic [2:0] IDX_IER     = 3'h1;
  localparam logic [2:0] IDX_FCR     = 3'h2;
  localparam logic [2:0] IDX_LCR     = 3'h3;
  localparam logic [2:0] IDX_MCR     = 3'h4;
  localparam logic [2:0] IDX_LSR     = 3'h5;
  localparam logic [2:0] IDX_MSR     = 3'h6;
  localparam logic [2:0] IDX_SPR     = 3'h7;
  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  //**************************************************
  // Reset values and codes
  //**************************************************
  localparam logic [3:0] RST_IER     = 4'h0;
  localparam logic [7:0] RST_LCR     = 8'h00;
  localparam logic [4:0] RST_MCR     = 5'h00;
  localparam logic [7:0] RST_SPR     = 8'hFF;
  localparam logic [3:0] ISR_NONE    = 4'h1;
  localparam logic [3:0] ISR_LINE    = 4'h6;
  localparam logic [3:0] ISR_RXRDY   = 4'h4;
  localparam logic [3:0] ISR_RXTO    = 4'hC;
  localparam logic [3:0] ISR_THRE    = 4'h2;
  localparam logic [3:0] ISR_MODEM   = 4'h0;
  //**************************************************
  // FIFO, baud and timeout counts
  //**************************************************
  localparam logic [4:0]      FIFO_DEPTH = 5'h10;
  localparam logic [3:0][4:0] RX_TRIG    = {5'h0E, 5'h08, 5'h04, 5'h01};
  localparam logic [4:0]      TX_TRIG    = 5'h08;
  localparam logic [5:0]      BIT_LAST   = 6'h0F;
  localparam logic [5:0]      START_MID  = 6'h07;
  localparam logic [5:0]      STOP1_LAST = 6'h0F;
  localparam logic [5:0]      STOP15_LST = 6'h17;
  localparam logic [5:0]      STOP2_LAST = 6'h1F;
  localparam logic [3:0]      WL_BASE    = 4'h5;
  localparam logic [6:0]      TO_MUL     = 7'h04;
  localparam logic [6:0]      TO_ADD     = 7'h0C;
  //**************************************************
  // Types
  //**************************************************
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufb_txst_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufb_rxst_t;
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } ufb_modem_t;
  typedef struct packed {
    logic [5:0]       sync1;
    logic [5:0]       sync2;
    logic [3:0]       int_enable_reg;
    logic             fifoEn;
    logic             dmaMode;
    logic [1:0]       trig;
    logic [7:0]       line_control_reg;
    logic [4:0]       modem_control_reg;
    logic [7:0]       spr;
    logic [7:0]       dll;
    logic [7:0]       divisor_high_byte;
    logic [15:0][7:0] txMem;
    logic [3:0]       txWr;
    logic [3:0]       txRd;
    logic [4:0]       txCnt;
    logic [15:0][7:0] rxMem;
    logic [3:0]       rxWr;
    logic [3:0]       rxRd;
    logic [4:0]       rxCnt;
    logic             oe;
    logic             pe;
    logic             fe;
    logic             thrInt;
    logic             toFlag;
    logic [3:0]       delta;
    logic [3:0]       mPrev;
    logic [15:0]      baudCnt;
    logic             tick;
    ufb_txst_t        txSt;
    logic [5:0]       txTick;
    logic [3:0]       txBit;
    logic [7:0]       txSh;
    logic             txPar;
    logic             txLine;
    ufb_rxst_t        rxSt;
    logic [5:0]       rxTick;
    logic [3:0]       rxBit;
    logic [7:0]       rxSh;
    logic             rxPar;
    logic             rxPerr;
    logic [3:0]       toTick;
    logic [6:0]       toBits;
    logic             apValid;
    logic             apWrite;
    logic             apOk;
    logic [2:0]       apIdx;
    logic             rdPend;
    logic [31:0]      hrdata;
    logic             hready;
    logic             intOut;
    logic             intOe;
    logic             txdPin;
    logic             dtrN;
    logic             rtsN;
    logic             op1N;
    logic             op2N;
    logic             txDmaReq;
    logic             rxDmaReq;
  } ufb_state_t;
endpackage
`default_nettype wire

// *** hw/ufb_uart.sv ***
// UART channel with FIFOs, timeout, baud divisor, DMA signalling and loopback
`timescale 1ns/1ps
`default_nettype none
module ufb_uart
  import ufb_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              rxdPin,
  input  wire logic              ctsN,
  input  wire logic              dsrN,
  input  wire logic              dcdN,
  input  wire logic              riN,
  input  wire logic              intOutputSelectPin,
  output logic                   txdPin,
  output logic                   dtrN,
  output logic                   rtsN,
  output logic                   userOutputOneN,
  output logic                   userOutputTwoN,
  output logic                   intOut,
  output logic                   intOe,
  output logic                   txDmaReq,
  output logic                   rxDmaReq
);
  ufb_state_t s;
  ufb_state_t n;
  logic        loopOn;
  logic        dlab;
  logic        rxLine;
  ufb_modem_t  mdm;
  logic [15:0] div;
  logic [3:0]  wlen;
  logic [6:0]  toLim;
  logic [4:0]  trig;
  logic [4:0]  cap;
  logic        rxAvail;
  logic        lineErr;
  logic        tmo;
  logic [3:0]  isrCode;
  logic [7:0]  lsrVal;
  logic [5:0]  stopLast;
  logic        take;
  logic        txParBit;
  logic        rxParBit;

  //**************************************************
  // Derived conditions
  //**************************************************
  assign loopOn   = s.modem_control_reg[4];
  assign dlab     = s.line_control_reg[7];
  assign rxLine   = loopOn ? s.txLine : s.sync2[0];
  assign mdm      = loopOn ? ufb_modem_t'(s.modem_control_reg[3:0]) : ufb_modem_t'(~s.sync2[4:1]);
  assign div      = {s.divisor_high_byte, s.dll};
  assign wlen     = WL_BASE + {2'h0, s.line_control_reg[1:0]};
  assign toLim    = {3'h0, wlen} * TO_MUL + TO_ADD;
  assign trig     = RX_TRIG[s.trig];
  assign cap      = s.fifoEn ? FIFO_DEPTH : 5'h01;
  assign rxAvail  = s.fifoEn ? (s.rxCnt >= trig) : (s.rxCnt != 5'h00);
  assign lineErr  = s.oe | s.pe | s.fe;
  assign tmo      = s.toFlag & (s.rxCnt != 5'h00);
  assign take     = hsel & htrans[1] & hready;
  assign txParBit = s.line_control_reg[5] ? ~s.line_control_reg[4] : (s.txPar ^ ~s.line_control_reg[4]);
  assign rxParBit = s.line_control_reg[5] ? ~s.line_control_reg[4] : (s.rxPar ^ ~s.line_control_reg[4]);
  assign stopLast = !s.line_control_reg[2] ? STOP1_LAST : (wlen == WL_BASE) ? STOP15_LST : STOP2_LAST;
  assign isrCode  = (s.int_enable_reg[2] && lineErr) ? ISR_LINE :
                    (s.int_enable_reg[0] && rxAvail) ? ISR_RXRDY :
                    (s.int_enable_reg[0] && tmo) ? ISR_RXTO :
                    (s.int_enable_reg[1] && s.thrInt) ? ISR_THRE :
                    (s.int_enable_reg[3] && s.delta != 4'h0) ? ISR_MODEM : ISR_NONE;
  assign lsrVal   = {s.fifoEn & (s.pe | s.fe),
                     (s.txCnt == 5'h00) && (s.txSt == TX_IDLE),
                     s.txCnt < cap,
                     1'b0, s.fe, s.pe, s.oe,
                     s.rxCnt != 5'h00};

  //**************************************************
  // Next state
  //**************************************************
  always_comb begin
    logic       tPush;
    logic       tPop;
    logic       rPush;
    logic       rPop;
    logic       toClr;
    logic       txRst;
    logic       rxRst;
    logic       thrClr;
    logic [7:0] rd;
    logic [7:0] wd;
    tPush  = 1'b0;
    tPop   = 1'b0;
    rPush  = 1'b0;
    rPop   = 1'b0;
    toClr  = 1'b0;
    txRst  = 1'b0;
    rxRst  = 1'b0;
    thrClr = 1'b0;
    rd     = 8'h00;
    wd     = hwdata[7:0];
    n      = s;
    n.sync1 = {intOutputSelectPin, dcdN, riN, dsrN, ctsN, rxdPin};
    n.sync2 = s.sync1;

    // Baud divisor, one tick per sixteenth of a bit
    n.tick = 1'b0;
    if (div != 16'h0000) begin
      if (s.baudCnt >= div - 16'h0001) begin
        n.baudCnt = 16'h0000;
        n.tick    = 1'b1;
      end else begin
        n.baudCnt = s.baudCnt + 16'h0001;
      end
    end

    // Bus address phase
    n.apValid = take;
    if (take) begin
      n.apWrite = hwrite;
      n.apIdx   = haddr[4:2];
      n.apOk    = (haddr[ADDR_W-1:5] == '0) && (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);
    end
    if (take && !hwrite) begin
      n.hready = 1'b0;
      n.rdPend = 1'b1;
    end

    // Bus write data phase
    if (s.apValid && s.apWrite && s.apOk) begin
      unique case (s.apIdx)
        IDX_DATA: begin
          if (dlab) begin
            n.dll = wd;
          end else if (s.txCnt < cap) begin
            n.txMem[s.txWr] = wd;
            tPush  = 1'b1;
            thrClr = 1'b1;
          end
        end
        IDX_IER: begin
          if (dlab) begin
            n.divisor_high_byte = wd;
          end else begin
            n.int_enable_reg = wd[3:0];
          end
        end
        IDX_FCR: begin
          n.fifoEn  = wd[0];
          n.dmaMode = wd[3];
          n.trig    = wd[7:6];
          rxRst     = wd[1] | (wd[0] != s.fifoEn);
          txRst     = wd[2] | (wd[0] != s.fifoEn);
        end
        IDX_LCR: n.line_control_reg = wd;
        IDX_MCR: n.modem_control_reg = wd[4:0];
        IDX_SPR: n.spr = wd;
        IDX_LSR, IDX_MSR: ;
      endcase
    end

    // Bus read data phase, one wait state
    if (s.rdPend) begin
      n.rdPend = 1'b0;
      n.hready = 1'b1;
      if (s.apOk) begin
        unique case (s.apIdx)
          IDX_DATA: begin
            if (dlab) begin
              rd = s.dll;
            end else begin
              rd    = s.rxMem[s.rxRd];
              rPop  = s.rxCnt != 5'h00;
              toClr = 1'b1;
            end
          end
          IDX_IER: rd = dlab ? s.divisor_high_byte : {4'h0, s.int_enable_reg};
          IDX_FCR: begin
            rd     = {s.fifoEn, s.fifoEn, 2'h0, isrCode};
            thrClr = isrCode == ISR_THRE;
          end
          IDX_LCR: rd = s.line_control_reg;
          IDX_MCR: rd = {3'h0, s.modem_control_reg};
          IDX_LSR: begin
            rd   = lsrVal;
            n.oe = 1'b0;
            n.pe = 1'b0;
            n.fe = 1'b0;
          end
          IDX_MSR: begin
            rd      = {mdm, s.delta};
            n.delta = 4'h0;
          end
          IDX_SPR: rd = s.spr;
        endcase
      end
      n.hrdata = {24'h000000, rd};
    end

    // Transmitter
    if (s.tick) begin
      if (s.txSt != TX_IDLE) begin
        n.txTick = s.txTick + 6'h01;
      end
      unique case (s.txSt)
        TX_IDLE: begin
          if (s.txCnt != 5'h00) begin
            n.txSh   = s.txMem[s.txRd];
            tPop     = 1'b1;
            n.txSt   = TX_START;
            n.txTick = 6'h00;
            n.txLine = 1'b0;
            n.txPar  = 1'b0;
            n.txBit  = 4'h0;
          end
        end
        TX_START, TX_DATA: begin
          if (s.txTick == BIT_LAST) begin
            n.txTick = 6'h00;
            if (s.txSt == TX_DATA && s.txBit == wlen) begin
              n.txSt   = s.line_control_reg[3] ? TX_PAR : TX_STOP;
              n.txLine = s.line_control_reg[3] ? txParBit : 1'b1;
            end else begin
              n.txSt   = TX_DATA;
              n.txLine = s.txSh[0];
              n.txPar  = s.txPar ^ s.txSh[0];
              n.txSh   = {1'b0, s.txSh[7:1]};
              n.txBit  = s.txBit + 4'h1;
            end
          end
        end
        TX_PAR: begin
          if (s.txTick == BIT_LAST) begin
            n.txTick = 6'h00;
            n.txSt   = TX_STOP;
            n.txLine = 1'b1;
          end
        end
        TX_STOP: begin
          if (s.txTick == stopLast) begin
            n.txSt = TX_IDLE;
          end
        end
      endcase
    end

    // Receiver, sampling at bit centres
    if (s.tick) begin
      n.rxTick = s.rxTick + 6'h01;
      unique case (s.rxSt)
        RX_IDLE: begin
          n.rxTick = 6'h00;
          if (!rxLine) begin
            n.rxSt = RX_START;
          end
        end
        RX_START: begin
          if (s.rxTick == START_MID) begin
            n.rxTick = 6'h00;
            n.rxSt   = rxLine ? RX_IDLE : RX_DATA;
            n.rxBit  = 4'h0;
            n.rxPar  = 1'b0;
          end
        end
        RX_DATA: begin
          if (s.rxTick == BIT_LAST) begin
            n.rxTick = 6'h00;
            n.rxSh   = {rxLine, s.rxSh[7:1]};
            n.rxPar  = s.rxPar ^ rxLine;
            n.rxBit  = s.rxBit + 4'h1;
            if (s.rxBit + 4'h1 == wlen) begin
              n.rxSt = s.line_control_reg[3] ? RX_PAR : RX_STOP;
            end
            n.rxPerr = 1'b0;
          end
        end
        RX_PAR: begin
          if (s.rxTick == BIT_LAST) begin
            n.rxTick = 6'h00;
            n.rxPerr = rxLine != rxParBit;
            n.rxSt   = RX_STOP;
          end
        end
        RX_STOP: begin
          if (s.rxTick == BIT_LAST) begin
            n.rxSt = RX_IDLE;
            toClr  = 1'b1;
            if (s.rxCnt < cap) begin
              n.rxMem[s.rxWr] = s.rxSh >> (4'h8 - wlen);
              rPush = 1'b1;
            end else begin
              n.oe = 1'b1;
            end
            n.fe = n.fe | !rxLine;
            n.pe = n.pe | s.rxPerr;
          end
        end
      endcase
    end

    // Receive timeout, one count per bit time
    if (toClr || s.rxCnt == 5'h00) begin
      n.toTick = 4'h0;
      n.toBits = 7'h00;
      n.toFlag = 1'b0;
    end else if (s.tick) begin
      n.toTick = s.toTick + 4'h1;
      if (s.toTick == BIT_LAST[3:0] && s.toBits != 7'h7F) begin
        n.toBits = s.toBits + 7'h01;
      end
    end
    if (s.fifoEn && s.toBits >= toLim && s.rxCnt != 5'h00 && s.rxCnt < trig) begin
      n.toFlag = 1'b1;
    end

    // FIFO pointers and counts
    if (tPush) begin
      n.txWr = s.txWr + 4'h1;
    end
    if (tPop) begin
      n.txRd = s.txRd + 4'h1;
    end
    n.txCnt = s.txCnt + {4'h0, tPush} - {4'h0, tPop};
    if (rPush) begin
      n.rxWr = s.rxWr + 4'h1;
    end
    if (rPop) begin
      n.rxRd = s.rxRd + 4'h1;
    end
    n.rxCnt = s.rxCnt + {4'h0, rPush} - {4'h0, rPop};
    if (txRst) begin
      n.txWr  = 4'h0;
      n.txRd  = 4'h0;
      n.txCnt = 5'h00;
    end
    if (rxRst) begin
      n.rxWr  = 4'h0;
      n.rxRd  = 4'h0;
      n.rxCnt = 5'h00;
    end

    // Transmit empty flag, set wins over clear
    if (thrClr) begin
      n.thrInt = 1'b0;
    end
    if ((tPop && !tPush && s.txCnt == 5'h01) || (n.int_enable_reg[1] && !s.int_enable_reg[1] && s.txCnt == 5'h00)) begin
      n.thrInt = 1'b1;
    end

    // Modem change flags, set wins over clear
    n.mPrev = mdm;
    n.delta = n.delta | (mdm ^ s.mPrev);

    // Registered outputs
    n.intOut   = isrCode != ISR_NONE;
    n.intOe    = s.sync2[5] | s.modem_control_reg[3];
    n.txdPin   = loopOn | (s.txLine & ~s.line_control_reg[6]);
    n.dtrN     = loopOn | ~s.modem_control_reg[0];
    n.rtsN     = loopOn | ~s.modem_control_reg[1];
    n.op1N     = loopOn | ~s.modem_control_reg[2];
    n.op2N     = loopOn | ~s.modem_control_reg[3];
    n.txDmaReq = s.dmaMode ? (s.txCnt < TX_TRIG) : (s.txCnt == 5'h00);
    n.rxDmaReq = s.dmaMode ? (s.rxCnt > trig) : (s.rxCnt != 5'h00);
  end

  //**************************************************
  // State register
  //**************************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s        <= '0;
      s.sync1  <= '1;
      s.sync2  <= '1;
      s.int_enable_reg    <= RST_IER;
      s.line_control_reg    <= RST_LCR;
      s.modem_control_reg    <= RST_MCR;
      s.spr    <= RST_SPR;
      s.hready <= 1'b1;
      s.txLine <= 1'b1;
      s.txdPin <= 1'b1;
      s.dtrN   <= 1'b1;
      s.rtsN   <= 1'b1;
      s.op1N   <= 1'b1;
      s.op2N   <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign hrdata         = s.hrdata;
  assign hreadyout      = s.hready;
  assign hresp          = 1'b0;
  assign txdPin         = s.txdPin;
  assign dtrN           = s.dtrN;
  assign rtsN           = s.rtsN;
  assign userOutputOneN = s.op1N;
  assign userOutputTwoN = s.op2N;
  assign intOut         = s.intOut;
  assign intOe          = s.intOe;
  assign txDmaReq       = s.txDmaReq;
  assign rxDmaReq       = s.rxDmaReq;
endmodule
`default_nettype wire

// *** sim/ufb_uart_props.sv ***
// Port checker for the UART channel
`timescale 1ns/1ps
`default_nettype none
module ufb_uart_props
  import ufb_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              txdPin,
  input wire logic              dtrN,
  input wire logic              rtsN,
  input wire logic              userOutputOneN,
  input wire logic              userOutputTwoN,
  input wire logic              intOutputSelectPin,
  input wire logic              intOe
);
  //**************************************************
  // Assertions
  //**************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic taken = hsel && htrans[1] && hready;
  sequence rdReq;
    taken && !hwrite;
  endsequence
  sequence mcrLoop;
    taken && hwrite && hsize == HSIZE_WORD && haddr == 12'h010 ##1 hwdata[4];
  endsequence
  rd_wait_a: assert property (rdReq |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  data_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed");
  upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  start_len_a: assert property ($fell(txdPin) |-> !txdPin [*8])
    else $error("start bit too short");
  sel_drive_a: assert property (intOutputSelectPin [*4] |=> intOe)
    else $error("interrupt driver off");
  loop_pins_a: assert property (mcrLoop |=> ##[1:3] (txdPin && dtrN && rtsN
    && userOutputOneN && userOutputTwoN))
    else $error("pins not detached");
endmodule
bind ufb_uart ufb_uart_props ufb_uart_props_i (.mclk(mclk), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txdPin(txdPin),
  .dtrN(dtrN), .rtsN(rtsN), .userOutputOneN(userOutputOneN),
  .userOutputTwoN(userOutputTwoN), .intOutputSelectPin(intOutputSelectPin), .intOe(intOe));
`default_nettype wire

// *** sim/ufb_remote.sv ***
// Far-end serial station model
`timescale 1ns/1ps
`default_nettype none
module ufb_remote #(
  parameter int BIT_CYC = 16
) (
  input  wire logic mclk,
  input  wire logic txdPin,
  output var logic  rxdPin,
  output var logic  ctsN,
  output var logic  dsrN,
  output var logic  dcdN,
  output var logic  riN
);
  //**************************************************
  // Line model
  //**************************************************
  logic [7:0] gotByte;
  int         gotCnt = 0;
  initial begin
    rxdPin = 1'b1;
    {ctsN, dsrN, dcdN, riN} = 4'hF;
  end
  // Sends one 8N1 frame, LSB first
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxdPin <= f[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask
  // Captures frames from the channel at bit centres
  always begin
    @(negedge txdPin);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge mclk);
      gotByte[i] = txdPin;
    end
    repeat (2 * BIT_CYC) @(posedge mclk);
    gotCnt++;
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Register-level bench for the UART channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module testbench
  import ufb_pkg::*;
;
  //**************************************************
  // Signals and instances
  //**************************************************
  logic        mclk = 1'b0;
  logic        rstN = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h00000000;
  logic        selPin = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, txdPin, dtrN, rtsN, op1N, op2N;
  logic        intOut, intOe, txDmaReq, rxDmaReq, rxd, ctsN, dsrN, dcdN, riN;
  int          checks = 0;
  int          mismatches = 0;
  ufb_uart ufb_uart_i (.mclk(mclk), .reset_n(rstN), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxdPin(rxd), .ctsN(ctsN),
    .dsrN(dsrN), .dcdN(dcdN), .riN(riN), .intOutputSelectPin(selPin), .txdPin(txdPin),
    .dtrN(dtrN), .rtsN(rtsN), .userOutputOneN(op1N), .userOutputTwoN(op2N),
    .intOut(intOut), .intOe(intOe), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq));
  ufb_remote #(.BIT_CYC(16)) ufb_remote_i (.mclk(mclk), .txdPin(txdPin), .rxdPin(rxd),
    .ctsN(ctsN), .dsrN(dsrN), .dcdN(dcdN), .riN(riN));
  initial begin
    forever #4 mclk = ~mclk;
  end
  //**************************************************
  // Bus tasks
  //**************************************************
  task automatic busWr(input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsize <= HSIZE_WORD;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
  endtask
  task automatic busRd(input logic [11:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsize <= HSIZE_WORD;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    d = hrdata;
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [7:0] e, input string n);
    logic [31:0] d;
    busRd(a, d);
    `CHK(n, {24'h000000, e}, d)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge mclk);
    mismatches++;
    close_out();
  end
  //**************************************************
  // Tests
  //**************************************************
  initial begin
    logic [31:0] d;
    repeat (3) @(posedge mclk);
    rstN <= 1'b1;
    @(posedge mclk);
    rdChk(12'h014, 8'h60, "lsr reset");
    rdChk(12'h008, 8'h01, "isr reset");
    rdChk(12'h01C, 8'hFF, "spr reset");
    rdChk(12'h020, 8'h00, "unmapped");
    `CHK("oe off", 1'b0, intOe)
    busWr(12'h010, 8'h08);
    rdChk(12'h010, 8'h08, "mcr");
    `CHK("oe on", 1'b1, intOe)
    busWr(12'h004, 8'h02);
    rdChk(12'h004, 8'h02, "ier");
    `CHK("int thre", 1'b1, intOut)
    rdChk(12'h008, 8'h02, "isr thre");
    rdChk(12'h008, 8'h01, "isr served");
    `CHK("int low", 1'b0, intOut)
    busWr(12'h00C, 8'h83);
    busWr(12'h000, 8'h01);
    busWr(12'h004, 8'h00);
    rdChk(12'h000, 8'h01, "div low");
    busWr(12'h00C, 8'h03);
    rdChk(12'h004, 8'h02, "ier again");
    busWr(12'h000, 8'hA5);
    busRd(12'h014, d);
    `CHK("tx busy", 1'b0, d[6])
    while (ufb_remote_i.gotCnt == 0) @(posedge mclk);
    `CHK("tx byte", 8'hA5, ufb_remote_i.gotByte)
    rdChk(12'h014, 8'h60, "lsr done");
    busWr(12'h008, 8'hC1);
    busWr(12'h004, 8'h01);
    ufb_remote_i.sendByte(8'h3C);
    repeat (600) @(posedge mclk);
    rdChk(12'h008, 8'hC1, "isr early");
    repeat (150) @(posedge mclk);
    rdChk(12'h008, 8'hCC, "isr timeout");
    rdChk(12'h000, 8'h3C, "rx data");
    rdChk(12'h008, 8'hC1, "isr none");
    rdChk(12'h014, 8'h60, "lsr empty");
    busWr(12'h008, 8'h01);
    ufb_remote_i.sendByte(8'h81);
    rdChk(12'h008, 8'hC4, "isr trig");
    `CHK("rx dma0", 1'b1, rxDmaReq)
    busWr(12'h008, 8'h09);
    repeat (2) @(posedge mclk);
    `CHK("rx dma1", 1'b0, rxDmaReq)
    `CHK("tx dma1", 1'b1, txDmaReq)
    rdChk(12'h000, 8'h81, "rx trig");
    rdChk(12'h008, 8'hC1, "isr clr");
    busWr(12'h004, 8'h08);
    busWr(12'h010, 8'h15);
    rdChk(12'h008, 8'hC0, "isr modem");
    busRd(12'h018, d);
    `CHK("msr a", 4'h5, d[7:4])
    rdChk(12'h008, 8'hC1, "isr msr");
    busWr(12'h010, 8'h1A);
    busRd(12'h018, d);
    `CHK("msr b", 4'hA, d[7:4])
    busWr(12'h000, 8'h5A);
    repeat (300) @(posedge mclk);
    rdChk(12'h000, 8'h5A, "loop data");
    selPin <= 1'b1;
    busWr(12'h010, 8'h00);
    repeat (6) @(posedge mclk);
    `CHK("oe sel", 1'b1, intOe)
    close_out();
  end
endmodule
`default_nettype wire
